// ===== core/pcfd_pkg.sv
package pcfd_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00; // control word
  localparam logic [7:0] ADDR_STATUS    = 8'h04; // live state
  localparam logic [7:0] ADDR_LOCK_LEFT = 8'h08; // lock wait left

  // control field positions
  localparam int CTRL_SOFT_CLEAR = 0;  // write 1: phase clear pulse
  localparam int CTRL_FORCE_OFF  = 1;  // 1: outputs high impedance

  // status field positions
  localparam int ST_LOCKED   = 0;      // lock wait elapsed
  localparam int ST_TEST     = 1;      // bypass mode active
  localparam int ST_DIV_LO   = 2;      // divider count, two bits
  localparam int ST_SEL_LO   = 4;      // select code, two bits
  localparam int ST_FEEDBACK = 6;      // feedback pin level
  localparam int ST_ENABLED  = 7;      // outputs driven

  // reset values
  localparam logic [1:0]  DIV_RESET  = 2'h0;  // divider start phase
  localparam logic        FORCE_RST  = 1'b0;  // outputs not forced off
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int LOCK_TIME_US  = 50;   // longest lock interval
  localparam int CLK_PERIOD_NS = 100;  // 10 MHz core clock
  // longest time rounds down
  localparam int LOCK_CYCLES   = (LOCK_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int LOCK_W        = 10;   // counter width, holds 500

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic force_off;                   // software output disable
  } pcfd_ctrl_type;

  typedef struct packed {
    logic [2:0] four;                  // bank four lines
    logic [2:0] three;                 // bank three lines
    logic [2:0] two;                   // bank two lines
    logic [2:0] one;                   // bank one lines
  } pcfd_banks_type;

endpackage : pcfd_pkg

// ===== core/pcfd_core.sv
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps

// Operation
// - enable low drives outputs, high floats them
// - clear falling edge forces outputs low at once, divider zeroed at next edge
// - clear gives half-rate outputs a known phase
// - selects pick up to nine outputs by threes
// - test high bypasses the loop
// - banks one to three carry half or quarter
// - bank four carries half rate unless test is high
// - every output has even high/low split
// - lock wait after select, clear, enable, reset
// - re-enabling outputs restarts lock wait
// - two-bit counter divides the vco
// - LL none, LH one, HL two, HH three
module pcfd_core
  import pcfd_pkg::*;
#(
  parameter int ADDR_W = 8             // apb address width
)(
  input  wire logic              clk,                     // vco clock
  input  wire logic              reset,                   // async, high
  input  wire logic              reference_clock_in,      // reference
  input  wire logic              loop_feedback_in,        // fed-back out
  input  wire logic              half_rate_phase_clear_n, // phase clear
  input  wire logic              output_enable_n,         // enable, low
  input  wire logic              test_mode,               // bypass
  input  wire logic              bank_rate_select_hi,     // select msb
  input  wire logic              bank_rate_select_lo,     // select lsb
  output logic [2:0]             bank_one_clock_out,      // bank one
  output logic [2:0]             bank_two_clock_out,      // bank two
  output logic [2:0]             bank_three_clock_out,    // bank three
  output logic [2:0]             bank_four_clock_out,     // bank four
  output logic [11:0]            bank_clock_oe,           // drive enables
  output logic                   pll_locked,              // lock wait done
  input  wire logic              psel,                    // apb select
  input  wire logic              penable,                 // apb enable
  input  wire logic              pwrite,                  // apb write
  input  wire logic [ADDR_W-1:0] paddr,                   // apb address
  input  wire logic [31:0]       pwdata,                  // apb wdata
  output logic [31:0]            prdata,                  // apb rdata
  output logic                   pready,                  // apb ready
  output logic                   pslverr                  // apb error
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0]        div_count;        // two-bit vco divider
  logic              clear_n_prev;     // clear level last cycle
  logic [1:0]        sel_prev;         // select code last cycle
  logic              oe_prev;          // drive state last cycle
  logic [LOCK_W-1:0] lock_left;        // cycles until lock
  pcfd_ctrl_type     ctrl;             // software control
  logic              soft_clear;       // one-cycle software clear

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic [1:0] sel_code    = {bank_rate_select_hi,
                                  bank_rate_select_lo};
  wire logic       pin_clear   = clear_n_prev
                                 & ~half_rate_phase_clear_n;
  wire logic       clear_now   = pin_clear | soft_clear;
  wire logic       drive_on    = ~output_enable_n & ~ctrl.force_off;
  wire logic       sel_change  = sel_code != sel_prev;
  wire logic       oe_rise     = drive_on & ~oe_prev;
  wire logic       relock      = sel_change | clear_now | oe_rise;
  // divider taps, forced low during the clear cycle itself
  wire logic       tap_half    = div_count[0] & ~clear_now;
  wire logic       tap_quarter = div_count[1] & ~clear_now;

  // apb decode
  wire logic       setup_ph    = psel & ~penable;
  wire logic       access_ph   = psel & penable;
  wire logic       hit_ctrl    = paddr == ADDR_W'(ADDR_CTRL);
  wire logic       hit_status  = paddr == ADDR_W'(ADDR_STATUS);
  wire logic       hit_left    = paddr == ADDR_W'(ADDR_LOCK_LEFT);
  wire logic       mapped      = hit_ctrl | hit_status | hit_left;
  wire logic       wr_ctrl     = access_ph & pwrite & hit_ctrl;

  // ----------------------------------------------------------------
  // bank steering
  // ----------------------------------------------------------------
  pcfd_banks_type banks;               // per-bank line values
  logic [2:0]     bank_alt;            // bank runs at quarter rate

  genvar b;
  generate
    for (b = 0; b < 3; b++)
    begin : g_alt
      // code above bank index selects it
      assign bank_alt[b] = sel_code > 2'(b);
    end
  endgenerate

  // test mode passes the reference, else divider taps
  assign banks.one   = {3{test_mode ? reference_clock_in
                          : (bank_alt[0] ? tap_quarter : tap_half)}};
  assign banks.two   = {3{test_mode ? reference_clock_in
                          : (bank_alt[1] ? tap_quarter : tap_half)}};
  assign banks.three = {3{test_mode ? reference_clock_in
                          : (bank_alt[2] ? tap_quarter : tap_half)}};
  assign banks.four  = {3{test_mode ? reference_clock_in
                          : tap_half}};

  assign bank_one_clock_out   = banks.one;
  assign bank_two_clock_out   = banks.two;
  assign bank_three_clock_out = banks.three;
  assign bank_four_clock_out  = banks.four;
  assign bank_clock_oe        = {12{drive_on}};
  assign pll_locked           = lock_left == '0;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // counts every vco cycle; taps toggle at even duty
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      div_count <= DIV_RESET;
    else if (clear_now)
      div_count <= DIV_RESET;
    else
      div_count <= div_count + 2'h1;
  end

  // ----------------------------------------------------------------
  // edge history
  // ----------------------------------------------------------------
  // previous levels for edge and change detection
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      clear_n_prev <= 1'b1;
      sel_prev     <= 2'h0;
      oe_prev      <= 1'b0;
    end
    else
    begin
      clear_n_prev <= half_rate_phase_clear_n;
      sel_prev     <= sel_code;
      oe_prev      <= drive_on;
    end
  end

  // ----------------------------------------------------------------
  // lock wait
  // ----------------------------------------------------------------
  // reloads on any disturbance, counts down to lock
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      lock_left <= LOCK_W'(LOCK_CYCLES);
    else if (relock)
      lock_left <= LOCK_W'(LOCK_CYCLES);
    else if (lock_left != '0)
      lock_left <= lock_left - LOCK_W'(1);
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [31:0] read_word;              // selected read value
  always_comb
  begin
    read_word = WORD_ZERO;
    if (hit_ctrl)
      read_word[CTRL_FORCE_OFF] = ctrl.force_off;
    else if (hit_status)
    begin
      read_word[ST_LOCKED]            = pll_locked;
      read_word[ST_TEST]              = test_mode;
      read_word[ST_DIV_LO +: 2]       = div_count;
      read_word[ST_SEL_LO +: 2]       = sel_code;
      read_word[ST_FEEDBACK]          = loop_feedback_in;
      read_word[ST_ENABLED]           = drive_on;
    end
    else if (hit_left)
      read_word[LOCK_W-1:0] = lock_left;
  end

  // zero wait: read data and error captured in setup
  assign pready = 1'b1;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      prdata  <= WORD_ZERO;
      pslverr <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata  <= pwrite ? WORD_ZERO : read_word;
      pslverr <= ~mapped;
    end
  end

  // control register and self-clearing clear pulse
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl.force_off <= FORCE_RST;
      soft_clear     <= 1'b0;
    end
    else
    begin
      soft_clear <= wr_ctrl & pwdata[CTRL_SOFT_CLEAR];
      if (wr_ctrl)
        ctrl.force_off <= pwdata[CTRL_FORCE_OFF];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_outputs_enable: assert property (
    bank_clock_oe == {12{~output_enable_n & ~ctrl.force_off}})
    else $error("drive enable does not follow enable input");

  a_clear_low_now: assert property (
    ($fell(half_rate_phase_clear_n) && !test_mode) |->
      (bank_one_clock_out == 3'h0 && bank_four_clock_out == 3'h0))
    else $error("outputs not low on clear edge");

  a_clear_known_phase: assert property (
    $fell(half_rate_phase_clear_n) |=> div_count == DIV_RESET)
    else $error("divider not at start phase after clear");

  a_bank_select_map: assert property (
    (!test_mode && !clear_now && sel_code == 2'h2) |->
      (bank_two_clock_out == {3{div_count[1]}} &&
       bank_three_clock_out == {3{div_count[0]}}))
    else $error("select code steers wrong bank rate");

  a_test_bypass: assert property (
    test_mode |-> bank_three_clock_out == {3{reference_clock_in}})
    else $error("test mode does not bypass");

  a_bank_four_half: assert property (
    (!test_mode && !clear_now) |-> bank_four_clock_out
      == {3{div_count[0]}})
    else $error("bank four not at half rate");

  a_even_duty: assert property (
    (!test_mode && !clear_now && !soft_clear && div_count == 2'h0)
      ##1 (!clear_now)[*3] |->
      $past(tap_quarter, 2) == 1'b0 && tap_quarter == 1'b1)
    else $error("quarter tap not high for two of four");

  a_divider_step: assert property (
    !clear_now |=> div_count == 2'($past(div_count) + 2'h1))
    else $error("divider skipped a count");

  a_lock_restart: assert property (
    relock |=> (!pll_locked && lock_left == LOCK_W'(LOCK_CYCLES)))
    else $error("lock wait not restarted");

  a_lock_reenable: assert property (
    $rose(bank_clock_oe[0]) |-> ##1 !pll_locked [*8])
    else $error("lock claimed too soon after enable");

  a_apb_unmapped: assert property (
    (setup_ph && !mapped) |=> pslverr)
    else $error("unmapped access not flagged");

  a_soft_clear_phase: assert property (
    soft_clear |=> div_count == DIV_RESET)
    else $error("software clear left divider running");

  a_bank_one_map: assert property (
    (!test_mode && !clear_now && sel_code == 2'h1) |->
      (bank_one_clock_out == {3{div_count[1]}} &&
       bank_two_clock_out == {3{div_count[0]}}))
    else $error("code one steers wrong bank rate");

  a_lock_countdown: assert property (
    (!relock && lock_left != '0) |=>
      lock_left == LOCK_W'($past(lock_left) - LOCK_W'(1)))
    else $error("lock wait not counting down");

  a_force_off_float: assert property (
    ctrl.force_off |-> bank_clock_oe == 12'h000)
    else $error("outputs driven while forced off");

  c_clear_edge:  cover property ($fell(half_rate_phase_clear_n));
  c_select_all:  cover property (sel_code == 2'h3 && pll_locked);
  c_lock_reach:  cover property ($rose(pll_locked));
  c_test_enter:  cover property ($rose(test_mode));
  c_soft_clear:  cover property (soft_clear);

endmodule : pcfd_core

// ===== tb/pcfd_board_model.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// board side: reference source and feedback wiring
// ------------------------------------------------------------
module pcfd_board_model
  import pcfd_pkg::*;
(
  input  wire logic        fb_line,  // chosen output line
  input  wire logic        fb_oe,    // its drive enable
  output logic             ref_clk,  // reference clock
  output logic             fb_in     // feedback pin level
);
  logic last_fb;                     // last driven line level

  // fixed-rate, fixed-phase reference, period 300 ns
  // offset so its edges never share a time step with the core clock
  initial
  begin
    ref_clk = 1'b0;
    #75;
    forever #150 ref_clk = ~ref_clk;
  end

  // one output wired back; undriven line shows inverse of last level
  always @(fb_line or fb_oe)
    if (fb_oe)
      last_fb = fb_line;
  assign fb_in = fb_oe ? fb_line : ~last_fb;
endmodule : pcfd_board_model

// ===== tb/tb_pll_clock_fanout_divider.sv
`timescale 1ns/100ps

module tb_pll_clock_fanout_divider
  import pcfd_pkg::*;
;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  logic        clk, reset, clr_n, oe_n, test, sel_hi, sel_lo;
  logic        ref_clk, fb_in, locked, psel, penable, pwrite;
  logic        pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  b1, b2, b3, b4;
  logic [11:0] oe;
  int          fail_count, num_checks;
  logic [1:0]  rows [4] = '{2'h0, 2'h1, 2'h2, 2'h3}; // select codes

  pcfd_core DUT (.clk(clk), .reset(reset), .reference_clock_in(ref_clk),
    .loop_feedback_in(fb_in), .half_rate_phase_clear_n(clr_n),
    .output_enable_n(oe_n), .test_mode(test),
    .bank_rate_select_hi(sel_hi), .bank_rate_select_lo(sel_lo),
    .bank_one_clock_out(b1), .bank_two_clock_out(b2),
    .bank_three_clock_out(b3), .bank_four_clock_out(b4),
    .bank_clock_oe(oe), .pll_locked(locked), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  pcfd_board_model board (.fb_line(b4[0]), .fb_oe(oe[9]),
    .ref_clk(ref_clk), .fb_in(fb_in));

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  always #50 clk = ~clk;             // 10 MHz

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // expected lines {four,three,two,one} for divider count and code
  function automatic logic [11:0] exp_out(input int c, input int s);
    logic h, q;
    h = c[0];
    q = c[1];
    return {{3{h}}, {3{s >= 3 ? q : h}}, {3{s >= 2 ? q : h}},
            {3{s >= 1 ? q : h}}};
  endfunction : exp_out

  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    if (n >= 20) chk(32'h1, 32'h0);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wait_neg(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_neg

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------
  initial
  begin
    #2_000_000;
    fail_count++;
    finish_test();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial
  begin
    clk = 0; reset = 1; clr_n = 1; oe_n = 0; test = 0;
    {sel_hi, sel_lo} = 2'h0; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0; fail_count = 0; num_checks = 0;
    repeat (10) @(posedge clk);
    reset <= 0;
    // each select code: clear, then eight divider phases
    foreach (rows[i])
    begin
      @(posedge clk);
      {sel_hi, sel_lo} <= rows[i];
      clr_n <= 1'b0;
      @(negedge clk);
      chk({b4, b3, b2, b1}, 32'h0);
      @(posedge clk);
      clr_n <= 1'b1;
      for (int p = 0; p < 8; p++)
      begin
        @(negedge clk);
        chk({b4, b3, b2, b1}, exp_out(p % 4, i));
      end
    end
    wait_neg(380);
    chk(locked, 1'b0);
    wait_neg(130);
    chk(locked, 1'b1);
    // disable and re-enable the outputs
    @(posedge clk) oe_n <= 1'b1;
    wait_neg(1);
    chk(oe, 12'h000);
    @(posedge clk) oe_n <= 1'b0;
    wait_neg(3);
    chk(oe, 12'hFFF);
    chk(locked, 1'b0);
    // bypass: every line follows the reference
    @(posedge clk) test <= 1'b1;
    repeat (6)
    begin
      wait_neg(1);
      chk({b4, b3, b2, b1}, {12{ref_clk}});
    end
    apb(1'b0, ADDR_STATUS, 32'h0, rd);
    chk({rd[ST_TEST], rd[ST_SEL_LO+:2], pslverr}, 4'hE);
    @(posedge clk) test <= 1'b0;
    // register side: force off, unmapped place
    apb(1'b1, ADDR_CTRL, 32'h2, rd);
    wait_neg(1);
    chk(oe, 12'h000);
    apb(1'b1, ADDR_CTRL, 32'h0, rd);
    wait_neg(1);
    chk(oe, 12'hFFF);
    // software phase clear, then the restarted lock wait
    apb(1'b1, ADDR_CTRL, 32'h1, rd);
    wait_neg(1);
    chk({b4, b3, b2, b1}, 32'h0);
    wait_neg(2);
    chk({b4, b3, b2, b1}, exp_out(1, 3));
    apb(1'b0, ADDR_LOCK_LEFT, 32'h0, rd);
    chk(rd, LOCK_CYCLES - 2);
    apb(1'b0, 8'h3C, 32'h0, rd);
    chk(pslverr, 1'b1);
    chk(rd, 32'h0);
    // reset in mid-run
    @(posedge clk) reset <= 1'b1;
    wait_neg(2);
    chk({locked, b4, b3, b2, b1}, 32'h0);
    // release again: divider restarts from its start phase
    @(posedge clk) reset <= 1'b0;
    wait_neg(1);
    chk({b4, b3, b2, b1}, exp_out(0, 3));
    wait_neg(1);
    chk({locked, b4, b3, b2, b1}, {1'b0, exp_out(1, 3)});
    finish_test();
  end
endmodule : tb_pll_clock_fanout_divider
